//--- common/wake_pkg.sv
// Constants shared by the link-on notifier and its request serialiser.
// Assumes a single 20 MHz clock and APB access to the register file.
package wake_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned WAKE_PERIOD_CYCLES = 8;
    localparam int unsigned WAKE_HALF_CYCLES = WAKE_PERIOD_CYCLES / 2;
    localparam int unsigned POWER_TIMEOUT_MS = 167;
    localparam int unsigned POWER_TIMEOUT_CYCLES = POWER_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned TIMER_W = 22;
    localparam logic [2:0] MAX_POWER_CLASS = 3'h4;

    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [11:0] MASK_ADDR = 12'h008;
    localparam logic [11:0] STATE_ADDR = 12'h00c;
    localparam logic [11:0] REQ_ADDR = 12'h010;
    localparam logic [11:0] PMCSR_ADDR = 12'h048;

    localparam int unsigned CTRL_LINK_CTRL_BIT = 0;
    localparam int unsigned CTRL_RESUME_EN_BIT = 1;
    localparam int unsigned CTRL_LINK_INIT_BIT = 2;
    localparam int unsigned CTRL_CLASS_LSB = 4;
    localparam logic [2:0] CTRL_CLASS_RESET = 3'h0;

    localparam int unsigned EV_PORT = 0;
    localparam int unsigned EV_CFG_TIMEOUT = 1;
    localparam int unsigned EV_CABLE_POWER = 2;
    localparam int unsigned EV_STATE_TIMEOUT = 3;
    localparam int unsigned EV_NOTIFY_START = 4;
    localparam int unsigned EV_W = 5;
    localparam logic [4:0] MASK_RESET = 5'h00;

    localparam int unsigned PM_STATE_LSB = 0;
    localparam int unsigned PM_EVENT_BIT = 15;
    localparam logic [1:0] PM_D0 = 2'h0;
    localparam logic [1:0] PM_D2 = 2'h2;
    localparam logic [1:0] PM_D3 = 2'h3;

    localparam int unsigned REQ_W = 8;
    localparam logic [3:0] REQ_FRAME_BITS = 4'h9;
endpackage

//--- design/service_request_tx.sv
// Serialiser for link service requests: a start bit, then the request word MSB first.
// Assumes start is a one-cycle pulse; a start while busy is ignored.
`timescale 1ns/10ps
module service_request_tx (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [wake_pkg::REQ_W-1:0] word,
    output logic service_request_out,
    output logic busy
);
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_t;
    typedef struct packed {
        tx_state_t st;
        logic [3:0] left;
        logic [wake_pkg::REQ_W:0] sh;
        logic line;
    } tx_t;
    tx_t q, d;

    always_comb begin
        d = q;
        case (q.st)
            TX_IDLE: begin
                d.line = 1'b0;
                if (start) begin
                    d.st = TX_SHIFT;
                    d.sh = {1'b1, word};
                    d.left = wake_pkg::REQ_FRAME_BITS;
                end
            end
            TX_SHIFT: begin
                d.line = q.sh[wake_pkg::REQ_W];
                d.sh = {q.sh[wake_pkg::REQ_W-1:0], 1'b0};
                d.left = q.left - 4'h1;
                if (q.left == 4'h1) begin
                    d.st = TX_IDLE;
                end
            end
            default: d.st = TX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign service_request_out = q.line;
    assign busy = (q.st == TX_SHIFT);
endmodule

//--- design/link_on_notifier.sv
// Link-on notifier: physical-side wake generator and link-side power event capture.
// Assumes APB from a single master on pclk; event inputs are one-cycle pulses.
`timescale 1ns/10ps
module link_on_notifier #(
    parameter int unsigned POWER_TIMEOUT = wake_pkg::POWER_TIMEOUT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_power_status,
    input wire logic link_on_packet_rx,
    input wire logic bus_reset,
    input wire logic port_event_irq,
    input wire logic config_timeout_irq,
    input wire logic cable_power_irq,
    input wire logic state_timeout_irq,
    input wire logic wake_notify_in,
    output logic wake_notify_out,
    output logic wake_notify_oe_n,
    output logic service_request_out,
    output logic irq
);
    typedef struct packed {
        logic link_control_bit;
        logic resuming_port_irq_en;
        logic link_init;
        logic [2:0] pclass;
        logic [wake_pkg::EV_W-1:0] status;
        logic [wake_pkg::EV_W-1:0] mask;
        logic [1:0] pm_state;
        logic power_event_status;
        logic notify;
        logic pkt;
        logic pwr_pend;
        logic [1:0] div;
        logic wave;
        logic oe_n;
        logic [wake_pkg::TIMER_W-1:0] timer;
        logic sync1;
        logic sync2;
        logic sync3;
        logic [31:0] rdata;
        logic err;
    } state_t;
    state_t q, d;

    localparam logic [wake_pkg::TIMER_W-1:0] TIMEOUT_LAST = wake_pkg::TIMER_W'(POWER_TIMEOUT - 1);
    localparam logic [1:0] HALF_LAST = 2'(wake_pkg::WAKE_HALF_CYCLES - 1);

    function automatic logic known_addr(input logic [11:0] a);
        return a == wake_pkg::CTRL_ADDR || a == wake_pkg::STATUS_ADDR || a == wake_pkg::MASK_ADDR ||
            a == wake_pkg::STATE_ADDR || a == wake_pkg::REQ_ADDR || a == wake_pkg::PMCSR_ADDR;
    endfunction

    logic setup, wr, link_inactive, irq_cause, pwr_ok, start, timeout, drop, honour, wake_edge;
    logic req_busy;
    logic [wake_pkg::EV_W-1:0] ev_set;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign link_inactive = !link_power_status || !q.link_control_bit;
    assign irq_cause = q.status[wake_pkg::EV_PORT] ||
        (q.resuming_port_irq_en && (q.status[wake_pkg::EV_CFG_TIMEOUT] ||
        q.status[wake_pkg::EV_CABLE_POWER] || q.status[wake_pkg::EV_STATE_TIMEOUT]));
    // The timeout cycle must not count as a power cause, or the timeout could never end notification.
    assign pwr_ok = q.pwr_pend && !timeout && (q.pclass <= wake_pkg::MAX_POWER_CLASS);
    assign start = link_on_packet_rx || irq_cause || pwr_ok;
    assign timeout = q.notify && q.pwr_pend && (q.timer == TIMEOUT_LAST);
    assign drop = (bus_reset && !irq_cause && !pwr_ok && !link_on_packet_rx) ||
        (timeout && !irq_cause && !q.pkt);
    assign honour = (q.pm_state == wake_pkg::PM_D2) || (q.pm_state == wake_pkg::PM_D3) ||
        (q.pm_state == wake_pkg::PM_D0 && !q.link_init);
    assign wake_edge = q.sync2 && !q.sync3;
    assign ev_set = {link_inactive && start && !q.notify, state_timeout_irq, cable_power_irq,
        config_timeout_irq, port_event_irq};

    always_comb begin
        d = q;
        d.oe_n = 1'b0;
        d.sync1 = wake_notify_in;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        d.status = q.status | ev_set;
        if (honour && wake_edge) begin
            d.power_event_status = 1'b1;
        end
        if (setup) begin
            d.err = !known_addr(paddr);
            d.rdata = 32'h0;
            case (paddr)
                wake_pkg::CTRL_ADDR: begin
                    d.rdata[wake_pkg::CTRL_LINK_CTRL_BIT] = q.link_control_bit;
                    d.rdata[wake_pkg::CTRL_RESUME_EN_BIT] = q.resuming_port_irq_en;
                    d.rdata[wake_pkg::CTRL_LINK_INIT_BIT] = q.link_init;
                    d.rdata[wake_pkg::CTRL_CLASS_LSB +: 3] = q.pclass;
                end
                wake_pkg::STATUS_ADDR: d.rdata[wake_pkg::EV_W-1:0] = q.status;
                wake_pkg::MASK_ADDR: d.rdata[wake_pkg::EV_W-1:0] = q.mask;
                wake_pkg::STATE_ADDR: d.rdata[5:0] = {req_busy, q.sync3, q.wave, q.pkt, q.pwr_pend, q.notify};
                wake_pkg::PMCSR_ADDR: begin
                    d.rdata[wake_pkg::PM_STATE_LSB +: 2] = q.pm_state;
                    d.rdata[wake_pkg::PM_EVENT_BIT] = q.power_event_status;
                end
                default: d.rdata = 32'h0;
            endcase
        end
        if (wr) begin
            case (paddr)
                wake_pkg::CTRL_ADDR: begin
                    d.link_control_bit = pwdata[wake_pkg::CTRL_LINK_CTRL_BIT];
                    d.resuming_port_irq_en = pwdata[wake_pkg::CTRL_RESUME_EN_BIT];
                    d.link_init = pwdata[wake_pkg::CTRL_LINK_INIT_BIT];
                    d.pclass = pwdata[wake_pkg::CTRL_CLASS_LSB +: 3];
                end
                wake_pkg::STATUS_ADDR: d.status = (q.status & ~pwdata[wake_pkg::EV_W-1:0]) | ev_set;
                wake_pkg::MASK_ADDR: d.mask = pwdata[wake_pkg::EV_W-1:0];
                wake_pkg::PMCSR_ADDR: begin
                    d.pm_state = pwdata[wake_pkg::PM_STATE_LSB +: 2];
                    if (pwdata[wake_pkg::PM_EVENT_BIT] && !(honour && wake_edge)) begin
                        d.power_event_status = 1'b0;
                    end
                end
                default: d.err = q.err;
            endcase
        end
        if (!link_inactive) begin
            d.notify = 1'b0;
            d.pkt = 1'b0;
            d.pwr_pend = 1'b0;
        end else begin
            if (link_on_packet_rx) begin
                d.pkt = 1'b1;
            end else if (bus_reset) begin
                d.pkt = 1'b0;
            end
            if (timeout) begin
                d.pwr_pend = 1'b0;
            end
            d.notify = start || (q.notify && !drop);
        end
        if (q.notify && q.pwr_pend && !timeout) begin
            d.timer = q.timer + 1'b1;
        end else begin
            d.timer = '0;
        end
        if (!d.notify) begin
            d.div = 2'h0;
            d.wave = 1'b0;
        end else begin
            d.div = q.div + 2'h1;
            if (!q.notify || q.div == HALF_LAST) begin
                d.wave = !q.notify || !q.wave;
                d.div = 2'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.oe_n <= 1'b1;
            q.pwr_pend <= 1'b1;
            q.pclass <= wake_pkg::CTRL_CLASS_RESET;
            q.mask <= wake_pkg::MASK_RESET;
            // The pin is pulled high while it floats in reset, so the synchroniser starts high.
            q.sync1 <= 1'b1;
            q.sync2 <= 1'b1;
            q.sync3 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    service_request_tx u_req (
        .pclk(pclk),
        .presetn(presetn),
        .start(wr && paddr == wake_pkg::REQ_ADDR),
        .word(pwdata[wake_pkg::REQ_W-1:0]),
        .service_request_out(service_request_out),
        .busy(req_busy)
    );

    assign pready = psel && penable;
    assign prdata = q.rdata;
    assign pslverr = psel && penable && q.err;
    assign wake_notify_out = q.wave;
    assign wake_notify_oe_n = q.oe_n;
    assign irq = |(q.status & q.mask);

    sequence s_wave_high;
        wake_notify_out && q.notify [*4];
    endsequence
    sequence s_sync_rise;
        $rose(wake_notify_in) ##1 honour [*3];
    endsequence

    property p_drive;
        @(posedge pclk) disable iff (!presetn) $past(presetn) |-> !wake_notify_oe_n;
    endproperty
    a_drive: assert property (p_drive) else $error("wake pin not driven after reset");
    property p_square;
        @(posedge pclk) disable iff (!presetn)
            ($rose(wake_notify_out) ##0 s_wave_high) |=> !wake_notify_out || !q.notify;
    endproperty
    a_square: assert property (p_square) else $error("wake high phase not four cycles");
    property p_low;
        @(posedge pclk) disable iff (!presetn) !q.notify |-> !wake_notify_out;
    endproperty
    a_low: assert property (p_low) else $error("wake output not low when idle");
    property p_pkt;
        @(posedge pclk) disable iff (!presetn)
            link_on_packet_rx && link_inactive && !q.notify |=> q.notify && wake_notify_out;
    endproperty
    a_pkt: assert property (p_pkt) else $error("packet did not start notification");
    property p_port;
        @(posedge pclk) disable iff (!presetn) q.status[wake_pkg::EV_PORT] && link_inactive |=> q.notify;
    endproperty
    a_port: assert property (p_port) else $error("port event did not start notification");
    property p_resume;
        @(posedge pclk) disable iff (!presetn)
            q.resuming_port_irq_en && (|q.status[3:1]) && link_inactive |=> q.notify;
    endproperty
    a_resume: assert property (p_resume) else $error("enabled event did not start notification");
    property p_power;
        @(posedge pclk) disable iff (!presetn)
            q.pwr_pend && !timeout && q.pclass <= 3'h4 && link_inactive |=> q.notify;
    endproperty
    a_power: assert property (p_power) else $error("power cycle did not start notification");
    property p_active;
        @(posedge pclk) disable iff (!presetn)
            link_power_status && q.link_control_bit |=> !q.notify && !wake_notify_out;
    endproperty
    a_active: assert property (p_active) else $error("notification kept with link active");
    property p_busreset;
        @(posedge pclk) disable iff (!presetn)
            bus_reset && !irq_cause && !pwr_ok && !link_on_packet_rx && !$past(link_on_packet_rx) |=> !q.notify;
    endproperty
    a_busreset: assert property (p_busreset) else $error("bus reset did not end packet notification");
    property p_timeout;
        @(posedge pclk) disable iff (!presetn) timeout |=> !q.pwr_pend && q.timer == '0;
    endproperty
    a_timeout: assert property (p_timeout) else $error("power notification did not time out");
    property p_pme;
        @(posedge pclk) disable iff (!presetn) s_sync_rise |=> q.power_event_status;
    endproperty
    a_pme: assert property (p_pme) else $error("wake input did not set power event status");
    property p_ignore;
        @(posedge pclk) disable iff (!presetn)
            !honour && !q.power_event_status && !(wr && paddr == wake_pkg::PMCSR_ADDR) |=> !q.power_event_status;
    endproperty
    a_ignore: assert property (p_ignore) else $error("wake input honoured in wrong state");
    property p_sync;
        @(posedge pclk) disable iff (!presetn) wake_edge |-> $past(wake_notify_in, 2) && !$past(wake_notify_in, 3);
    endproperty
    a_sync: assert property (p_sync) else $error("wake input edge not synchronised");
endmodule

//--- testbench/link_side_model.sv
// Behavioural link-layer side: resolves the wake pin, drives link power status, decodes request frames.
// Assumes the single pclk domain of the notifier and a pull-up on the wake pin.
`timescale 1ns/10ps
module link_side_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic power_on,
    input wire logic wake_notify_out,
    input wire logic wake_notify_oe_n,
    input wire logic service_request_out,
    output logic wake_line,
    output logic link_power_status,
    output logic [7:0] rx_word,
    output logic rx_valid
);
    logic [3:0] cnt_q;
    // A released pin is pulled high, so the link side then sees an active level.
    assign wake_line = wake_notify_oe_n ? 1'b1 : wake_notify_out;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            rx_word <= 8'h00;
            rx_valid <= 1'b0;
            link_power_status <= 1'b0;
        end else begin
            link_power_status <= power_on;
            if (cnt_q == 4'h0 && service_request_out) begin
                cnt_q <= 4'h8;
                rx_valid <= 1'b0;
            end else if (cnt_q != 4'h0) begin
                rx_word <= {rx_word[6:0], service_request_out};
                cnt_q <= cnt_q - 4'h1;
                rx_valid <= (cnt_q == 4'h1);
            end
        end
    end
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the link-on notifier, driving APB and the event inputs.
// Assumes the notifier keeps its own assertions and the partner decodes request frames.
`timescale 1ns/10ps
`define CHK(g, e) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, last_err, power_on = 1'b0;
    // Event pulses live in one vector so that a task can drive them by index.
    localparam int PKT = 0, BRST = 1, PEV = 2, EVP = 3;
    logic [5:0] pls = 6'h00;
    logic wake_notify_out, wake_notify_oe_n, wake_line, link_power_status, service_request_out, irq, rx_valid;
    logic [7:0] rx_word;
    int err_count = 0, cmp_count = 0;
    always #25 pclk = ~pclk;
    link_on_notifier #(.POWER_TIMEOUT(40)) i_link_on_notifier (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_power_status(link_power_status), .link_on_packet_rx(pls[PKT]),
        .bus_reset(pls[BRST]), .port_event_irq(pls[PEV]), .config_timeout_irq(pls[EVP]),
        .cable_power_irq(pls[EVP+1]), .state_timeout_irq(pls[EVP+2]), .wake_notify_in(wake_line),
        .wake_notify_out(wake_notify_out),
        .wake_notify_oe_n(wake_notify_oe_n), .service_request_out(service_request_out), .irq(irq));
    link_side_model i_link_side_model (.pclk(pclk), .presetn(presetn), .power_on(power_on),
        .wake_notify_out(wake_notify_out), .wake_notify_oe_n(wake_notify_oe_n),
        .service_request_out(service_request_out), .wake_line(wake_line),
        .link_power_status(link_power_status), .rx_word(rx_word), .rx_valid(rx_valid));
    task end_of_test();
        $display("errors=%0d compares=%0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            err_count++;
            end_of_test();
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task pulse(input int i);
        pls[i] <= 1'b1;
        @(posedge pclk);
        pls[i] <= 1'b0;
        @(posedge pclk);
    endtask
    task notify_is(input logic e);
        rd(wake_pkg::STATE_ADDR);
        `CHK(r[0], e)
    endtask
    task chk_wave();
        int n;
        logic p;
        n = 0;
        p = 1'b1;
        while (!(p === 1'b0 && wake_notify_out === 1'b1) && n < 20) begin
            p = wake_notify_out;
            @(posedge pclk);
            n++;
        end
        if (n == 20) begin
            err_count++;
            end_of_test();
        end
        for (int i = 1; i < 16; i++) begin
            @(posedge pclk);
            `CHK(wake_notify_out, 1'((i % 8) < 4))
        end
    endtask
    logic [1:0] pm_st [3] = '{wake_pkg::PM_D0, wake_pkg::PM_D2, wake_pkg::PM_D3};
    initial begin
        cycles(2);
        `CHK({wake_notify_oe_n, wake_notify_out, wake_line}, 3'h5)
        cycles(2);
        presetn <= 1'b1;
        cycles(2);
        `CHK(wake_notify_oe_n, 1'b0)
        chk_wave();
        cycles(40);
        repeat (8) begin
            @(posedge pclk);
            `CHK(wake_notify_out, 1'b0)
        end
        notify_is(1'b0);
        rd(wake_pkg::CTRL_ADDR);
        `CHK(r, 32'h0)
        rd(wake_pkg::MASK_ADDR);
        `CHK(r, 32'h0)
        wr(wake_pkg::CTRL_ADDR, 32'hffffffff);
        rd(wake_pkg::CTRL_ADDR);
        `CHK(r, 32'h77)
        wr(wake_pkg::CTRL_ADDR, 32'h0);
        wr(wake_pkg::PMCSR_ADDR, 32'h8000);
        pulse(PKT);
        notify_is(1'b1);
        chk_wave();
        rd(wake_pkg::PMCSR_ADDR);
        `CHK(r[15], 1'b1)
        pulse(BRST);
        notify_is(1'b0);
        `CHK(wake_notify_out, 1'b0)
        for (int k = 0; k < 3; k++) begin
            wr(wake_pkg::CTRL_ADDR, 32'h4);
            wr(wake_pkg::PMCSR_ADDR, {16'h0000, 1'b1, 13'h0000, pm_st[k]});
            pulse(PKT);
            cycles(12);
            rd(wake_pkg::PMCSR_ADDR);
            `CHK(r[15], 1'(k != 0))
            pulse(BRST);
            cycles(10);
        end
        wr(wake_pkg::CTRL_ADDR, 32'h1);
        power_on <= 1'b1;
        cycles(3);
        pulse(PKT);
        notify_is(1'b0);
        pulse(PEV);
        notify_is(1'b0);
        power_on <= 1'b0;
        cycles(4);
        notify_is(1'b1);
        pulse(BRST);
        notify_is(1'b1);
        rd(wake_pkg::STATUS_ADDR);
        `CHK(r, 32'h11)
        `CHK(irq, 1'b0)
        wr(wake_pkg::MASK_ADDR, 32'h1);
        `CHK(irq, 1'b1)
        wr(wake_pkg::STATUS_ADDR, 32'h1f);
        `CHK(irq, 1'b0)
        notify_is(1'b1);
        power_on <= 1'b1;
        cycles(4);
        notify_is(1'b0);
        for (int k = 0; k < 3; k++) begin
            power_on <= 1'b0;
            pulse(EVP + k);
            notify_is(1'b0);
            wr(wake_pkg::CTRL_ADDR, 32'h3);
            cycles(2);
            notify_is(1'b1);
            wr(wake_pkg::STATUS_ADDR, 32'h1f);
            power_on <= 1'b1;
            cycles(4);
            notify_is(1'b0);
            wr(wake_pkg::CTRL_ADDR, 32'h1);
        end
        rd(12'h020);
        `CHK({last_err, r}, {1'b1, 32'h0})
        wr(wake_pkg::REQ_ADDR, 32'ha5);
        for (int n = 0; n < 30 && rx_valid !== 1'b1; n++) begin
            @(posedge pclk);
        end
        `CHK({rx_valid, rx_word}, 9'h1a5)
        end_of_test();
    end
endmodule
